// >>> hw/status_cfg.svh
// constants for the questionable status and service-request block
`ifndef STATUS_CFG_SVH
`define STATUS_CFG_SVH
`define QUES_VOLT_SUM_BIT 0
`define QUES_CURR_SUM_BIT 1
`define QUES_FREQ_BIT 5
`define QUES_USED_MASK 16'h0023
`define RANGE_USED_MASK 16'h3f3f
`define OPER_USED_MASK 16'h7fff
`define STB_QUES_BIT 3
`define STB_MAV_BIT 4
`define STB_EVENT_SUM_BIT 5
`define STB_RQS_BIT 6
`define STB_OPER_BIT 7
`define STB_EAV_BIT 2
`define SRQ_SOURCE_MASK 8'hbc
`define ESR_OPC_BIT 0
`define ESR_PON_BIT 7
`define PTR_RESET 16'h7fff
`define ERR_NONE 16'h0000
`endif

// >>> hw/status_pkg.sv
// types shared by the status block
package status_pkg;
    typedef enum logic [3:0] {
        SEL_QUES, SEL_CURR, SEL_VOLT, SEL_OPER, SEL_STB, SEL_ESR,
        SEL_SRE, SEL_ESE, SEL_ERR
    } reg_sel_t;
    typedef enum logic [2:0] {
        PART_COND, PART_EVENT, PART_ENABLE, PART_PTR, PART_NTR
    } reg_part_t;
    typedef struct packed {
        logic read;
        logic write;
        reg_sel_t sel;
        reg_part_t part;
        logic [15:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic [5:0] currAbove;
        logic [5:0] currBelow;
        logic [5:0] voltAbove;
        logic [5:0] voltBelow;
        logic freqInvalid;
        logic [15:0] operCond;
    } meas_cond_t;
endpackage

// >>> hw/status_reg_group.sv
// one status register: condition, transition filters, event, enable
`timescale 1ns/1ns
`default_nettype none
`include "status_cfg.svh"
module status_reg_group #(
    parameter logic [15:0] USED = 16'hffff
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] cond,
    input wire logic clearStatus,
    input wire logic readEvent,
    input wire logic wrEnable,
    input wire logic wrPtr,
    input wire logic wrNtr,
    input wire logic [15:0] wdata,
    output logic [15:0] condOut,
    output logic [15:0] eventOut,
    output logic [15:0] enableOut,
    output logic [15:0] ptrOut,
    output logic [15:0] ntrOut,
    output logic summary
);
    logic [15:0] condReg;
    logic [15:0] eventReg;
    logic [15:0] enableReg;
    logic [15:0] ptrReg;
    logic [15:0] ntrReg;
    logic [15:0] hits;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) condReg <= 16'h0000;
        else condReg <= cond & USED;
    end

    assign hits = ((cond & ~condReg & ptrReg) | (~cond & condReg & ntrReg))
        & USED;

    // new hits win over the clear caused by a read or clear status
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) eventReg <= 16'h0000;
        else if (readEvent || clearStatus) eventReg <= hits;
        else eventReg <= eventReg | hits;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) enableReg <= 16'h0000;
        else if (wrEnable) enableReg <= wdata & USED;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptrReg <= `PTR_RESET & USED;
            ntrReg <= 16'h0000;
        end else if (clearStatus) begin
            ptrReg <= USED;
            ntrReg <= USED;
        end else begin
            if (wrPtr) ptrReg <= wdata & USED;
            if (wrNtr) ntrReg <= wdata & USED;
        end
    end

    assign condOut = condReg;
    assign eventOut = eventReg;
    assign enableOut = enableReg;
    assign ptrOut = ptrReg;
    assign ntrOut = ntrReg;
    assign summary = |(eventReg & enableReg);
endmodule
`default_nettype wire

// >>> hw/status_reporting.sv
// status reporting: questionable registers, status byte, error queue
`timescale 1ns/1ns
`default_nettype none
`include "status_cfg.svh"
module status_reporting
    import status_pkg::*;
#(
    parameter int ERR_DEPTH = 8,
    parameter int PTR_W = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire status_pkg::reg_req_t req,
    input wire status_pkg::meas_cond_t meas,
    input wire logic [7:0] esrEvents,
    input wire logic opcCommand,
    input wire logic settingsPending,
    input wire logic clearStatus,
    input wire logic deviceClear,
    input wire logic lineStart,
    input wire logic serialPoll,
    input wire logic errPush,
    input wire logic [15:0] errCode,
    input wire logic outputPending,
    output logic [15:0] rdata,
    output logic rdataValid,
    output logic [7:0] pollByte,
    output logic pollValid,
    output logic serviceRequest,
    output logic flushOutput,
    output logic flushInput
);
    import status_pkg::*;

    logic rstMeta;
    logic rstn;
    logic [15:0] voltCond;
    logic [15:0] currCond;
    logic [15:0] quesCond;
    logic [15:0] operCondIn;
    logic voltSum;
    logic currSum;
    logic quesSum;
    logic operSum;
    logic [15:0] vCond, vEvent, vEnable, vPtr, vNtr;
    logic [15:0] cCond, cEvent, cEnable, cPtr, cNtr;
    logic [15:0] qCond, qEvent, qEnable, qPtr, qNtr;
    logic [15:0] oCond, oEvent, oEnable, oPtr, oNtr;
    logic [7:0] esrReg;
    logic [7:0] eseReg;
    logic [7:0] sreReg;
    logic opcArmed;
    logic opcEvent;
    logic [15:0] errMem [ERR_DEPTH];
    logic [PTR_W-1:0] errHead;
    logic [PTR_W-1:0] errTail;
    logic [PTR_W:0] errCount;
    logic errEmpty;
    logic errFull;
    logic errPop;
    logic [7:0] statusByte;
    logic [15:0] readValue;
    logic rdEvent;
    logic eventSum;
    logic srqRaw;

    // reset is released through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta <= 1'b0;
            rstn <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstn <= rstMeta;
        end
    end

    assign voltCond = {2'h0, meas.voltBelow, 2'h0, meas.voltAbove};
    assign currCond = {2'h0, meas.currBelow, 2'h0, meas.currAbove};
    assign operCondIn = meas.operCond;

    always_comb begin
        quesCond = 16'h0000;
        quesCond[`QUES_VOLT_SUM_BIT] = voltSum;
        quesCond[`QUES_CURR_SUM_BIT] = currSum;
        quesCond[`QUES_FREQ_BIT] = meas.freqInvalid;
    end

    assign rdEvent = req.read && req.part == PART_EVENT;

    status_reg_group #(.USED(`RANGE_USED_MASK)) voltGroup (
        .clk(clk),
        .rstn(rstn),
        .cond(voltCond),
        .clearStatus(clearStatus),
        .readEvent(rdEvent && req.sel == SEL_VOLT),
        .wrEnable(req.write && req.sel == SEL_VOLT
            && req.part == PART_ENABLE),
        .wrPtr(req.write && req.sel == SEL_VOLT && req.part == PART_PTR),
        .wrNtr(req.write && req.sel == SEL_VOLT && req.part == PART_NTR),
        .wdata(req.wdata),
        .condOut(vCond),
        .eventOut(vEvent),
        .enableOut(vEnable),
        .ptrOut(vPtr),
        .ntrOut(vNtr),
        .summary(voltSum)
    );

    status_reg_group #(.USED(`RANGE_USED_MASK)) currGroup (
        .clk(clk),
        .rstn(rstn),
        .cond(currCond),
        .clearStatus(clearStatus),
        .readEvent(rdEvent && req.sel == SEL_CURR),
        .wrEnable(req.write && req.sel == SEL_CURR
            && req.part == PART_ENABLE),
        .wrPtr(req.write && req.sel == SEL_CURR && req.part == PART_PTR),
        .wrNtr(req.write && req.sel == SEL_CURR && req.part == PART_NTR),
        .wdata(req.wdata),
        .condOut(cCond),
        .eventOut(cEvent),
        .enableOut(cEnable),
        .ptrOut(cPtr),
        .ntrOut(cNtr),
        .summary(currSum)
    );

    status_reg_group #(.USED(`QUES_USED_MASK)) quesGroup (
        .clk(clk),
        .rstn(rstn),
        .cond(quesCond),
        .clearStatus(clearStatus),
        .readEvent(rdEvent && req.sel == SEL_QUES),
        .wrEnable(req.write && req.sel == SEL_QUES
            && req.part == PART_ENABLE),
        .wrPtr(req.write && req.sel == SEL_QUES && req.part == PART_PTR),
        .wrNtr(req.write && req.sel == SEL_QUES && req.part == PART_NTR),
        .wdata(req.wdata),
        .condOut(qCond),
        .eventOut(qEvent),
        .enableOut(qEnable),
        .ptrOut(qPtr),
        .ntrOut(qNtr),
        .summary(quesSum)
    );

    status_reg_group #(.USED(`OPER_USED_MASK)) operGroup (
        .clk(clk),
        .rstn(rstn),
        .cond(operCondIn),
        .clearStatus(clearStatus),
        .readEvent(rdEvent && req.sel == SEL_OPER),
        .wrEnable(req.write && req.sel == SEL_OPER
            && req.part == PART_ENABLE),
        .wrPtr(req.write && req.sel == SEL_OPER && req.part == PART_PTR),
        .wrNtr(req.write && req.sel == SEL_OPER && req.part == PART_NTR),
        .wdata(req.wdata),
        .condOut(oCond),
        .eventOut(oEvent),
        .enableOut(oEnable),
        .ptrOut(oPtr),
        .ntrOut(oNtr),
        .summary(operSum)
    );

    // operation complete waits until pending settings drain
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) opcArmed <= 1'b0;
        else if (opcCommand) opcArmed <= 1'b1;
        else if (opcArmed && !settingsPending) opcArmed <= 1'b0;
    end

    assign opcEvent = opcArmed && !opcCommand && !settingsPending;

    // power-on bit set on first cycle after reset; events win over clear
    logic ponSeen;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) ponSeen <= 1'b0;
        else ponSeen <= 1'b1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) esrReg <= 8'h00;
        else begin
            logic [7:0] newEv;
            newEv = esrEvents;
            newEv[`ESR_OPC_BIT] = esrEvents[`ESR_OPC_BIT] | opcEvent;
            newEv[`ESR_PON_BIT] = esrEvents[`ESR_PON_BIT] | !ponSeen;
            if (clearStatus || (req.read && req.sel == SEL_ESR))
                esrReg <= newEv;
            else
                esrReg <= esrReg | newEv;
        end
    end

    // enable masks survive clear status, only power-on clears them
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sreReg <= 8'h00;
            eseReg <= 8'h00;
        end else if (req.write) begin
            if (req.sel == SEL_SRE) sreReg <= req.wdata[7:0] & 8'hbf;
            if (req.sel == SEL_ESE) eseReg <= req.wdata[7:0];
        end
    end

    assign eventSum = |(esrReg & eseReg);

    // error queue: oldest entry first, pushes into a full queue are lost
    assign errEmpty = errCount == '0;
    assign errFull = errCount == (PTR_W+1)'(ERR_DEPTH);
    assign errPop = req.read && req.sel == SEL_ERR && !errEmpty;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            errHead <= '0;
            errTail <= '0;
            errCount <= '0;
        end else if (clearStatus) begin
            errHead <= '0;
            errTail <= '0;
            errCount <= '0;
        end else begin
            if (errPush && !errFull) errTail <= errTail + 1'b1;
            if (errPop) errHead <= errHead + 1'b1;
            if (errPush && !errFull && !errPop) errCount <= errCount + 1'b1;
            else if (errPop && !(errPush && !errFull))
                errCount <= errCount - 1'b1;
        end
    end

    // storage has no reset: head, tail and count decide what is valid
    always_ff @(posedge clk) begin
        if (errPush && !errFull && !clearStatus)
            errMem[errTail] <= errCode;
    end

    // bit 6 is the request summary itself, so the source mask leaves it out
    always_comb begin
        statusByte = 8'h00;
        statusByte[`STB_EAV_BIT] = !errEmpty;
        statusByte[`STB_QUES_BIT] = quesSum;
        statusByte[`STB_MAV_BIT] = outputPending;
        statusByte[`STB_EVENT_SUM_BIT] = eventSum;
        statusByte[`STB_OPER_BIT] = operSum;
        srqRaw = |(statusByte & sreReg & `SRQ_SOURCE_MASK);
        statusByte[`STB_RQS_BIT] = srqRaw;
    end

    // a read returns what the part holds before the read clears it;
    // unused bits are already masked inside each group
    always_comb begin
        readValue = 16'h0000;
        case (req.sel)
            SEL_VOLT: begin
                case (req.part)
                    PART_COND: readValue = vCond;
                    PART_EVENT: readValue = vEvent;
                    PART_ENABLE: readValue = vEnable;
                    PART_PTR: readValue = vPtr;
                    default: readValue = vNtr;
                endcase
            end
            SEL_CURR: begin
                case (req.part)
                    PART_COND: readValue = cCond;
                    PART_EVENT: readValue = cEvent;
                    PART_ENABLE: readValue = cEnable;
                    PART_PTR: readValue = cPtr;
                    default: readValue = cNtr;
                endcase
            end
            SEL_QUES: begin
                case (req.part)
                    PART_COND: readValue = qCond;
                    PART_EVENT: readValue = qEvent;
                    PART_ENABLE: readValue = qEnable;
                    PART_PTR: readValue = qPtr;
                    default: readValue = qNtr;
                endcase
            end
            SEL_OPER: begin
                case (req.part)
                    PART_COND: readValue = oCond;
                    PART_EVENT: readValue = oEvent;
                    PART_ENABLE: readValue = oEnable;
                    PART_PTR: readValue = oPtr;
                    default: readValue = oNtr;
                endcase
            end
            SEL_STB: readValue = {8'h00, statusByte};
            SEL_ESR: readValue = {8'h00, esrReg};
            SEL_SRE: readValue = {8'h00, sreReg};
            SEL_ESE: readValue = {8'h00, eseReg};
            SEL_ERR: readValue = errEmpty ? `ERR_NONE : errMem[errHead];
            default: readValue = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0000;
            rdataValid <= 1'b0;
        end else begin
            rdataValid <= req.read;
            if (req.read) rdata <= readValue;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pollByte <= 8'h00;
            pollValid <= 1'b0;
        end else begin
            pollValid <= serialPoll;
            if (serialPoll) pollByte <= statusByte;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) serviceRequest <= 1'b0;
        else serviceRequest <= srqRaw;
    end

    // buffers are held flushed through reset; settings are untouched here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flushOutput <= 1'b1;
            flushInput <= 1'b1;
        end else begin
            flushOutput <= deviceClear || lineStart;
            flushInput <= deviceClear;
        end
    end
endmodule
`default_nettype wire

// >>> verif/remote_ctrl_model.sv
// behavioural remote controller: register queries and serial polls
`timescale 1ns/1ns
`default_nettype none
module remote_ctrl_model
    import status_pkg::*;
(
    input wire logic clk,
    input wire logic [15:0] rdata,
    input wire logic rdataValid,
    input wire logic [7:0] pollByte,
    input wire logic pollValid,
    output var status_pkg::reg_req_t req,
    output var logic serialPoll
);
    initial begin
        req = '0;
        serialPoll = 1'b0;
    end
    // idle write data is inverted so a stale value is never mistaken
    task automatic xfer(input logic wr, input reg_sel_t s,
            input reg_part_t p, input logic [15:0] d,
            output logic [15:0] q);
        int i;
        q = 16'hxxxx;
        @(posedge clk);
        req.read <= !wr;
        req.write <= wr;
        req.sel <= s;
        req.part <= p;
        req.wdata <= d;
        @(posedge clk);
        req.read <= 1'b0;
        req.write <= 1'b0;
        req.wdata <= ~d;
        for (i = 0; i < 4 && !wr; i++) begin
            #1;
            if (rdataValid === 1'b1) begin
                q = rdata;
                break;
            end
            @(posedge clk);
        end
    endtask
    task automatic poll(output logic [7:0] q);
        int i;
        q = 8'hxx;
        @(posedge clk);
        serialPoll <= 1'b1;
        @(posedge clk);
        serialPoll <= 1'b0;
        for (i = 0; i < 4; i++) begin
            #1;
            if (pollValid === 1'b1) begin
                q = pollByte;
                break;
            end
            @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// >>> verif/status_reporting_chk.sv
// concurrent checks on the ports of the status reporting block
`timescale 1ns/1ns
`default_nettype none
`include "status_cfg.svh"
module status_reporting_chk
    import status_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire status_pkg::reg_req_t req,
    input wire logic deviceClear,
    input wire logic lineStart,
    input wire logic serialPoll,
    input wire logic [15:0] rdata,
    input wire logic rdataValid,
    input wire logic [7:0] pollByte,
    input wire logic pollValid,
    input wire logic serviceRequest,
    input wire logic flushOutput,
    input wire logic flushInput
);
    reg_sel_t lastSel;
    // the answer arrives one cycle later, so remember what was asked
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lastSel <= SEL_QUES;
        end else if (req.read) begin
            lastSel <= req.sel;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_READ_ANSWER: assert property (req.read |=> rdataValid)
        else $error("read not answered in the next cycle");
    AST_ANSWER_CAUSE: assert property (rdataValid |-> $past(req.read))
        else $error("read data valid without a read");
    AST_RDATA_HOLD: assert property (!rdataValid |-> $stable(rdata))
        else $error("read data moved without a read");
    AST_RANGE_ZERO: assert property (rdataValid &&
        (lastSel == SEL_CURR || lastSel == SEL_VOLT) |->
        (rdata & ~`RANGE_USED_MASK) == 16'h0000)
        else $error("unused range bit reads one");
    AST_QUES_ZERO: assert property (rdataValid &&
        lastSel == SEL_QUES |-> (rdata & ~`QUES_USED_MASK) == 16'h0000)
        else $error("unused questionable bit reads one");
    AST_POLL_ANSWER: assert property (serialPoll |=> pollValid)
        else $error("serial poll not answered");
    AST_POLL_CAUSE: assert property (pollValid |-> $past(serialPoll))
        else $error("poll byte valid without a poll");
    AST_DEVCLR_FLUSH: assert property (deviceClear |=>
        flushOutput && flushInput)
        else $error("device clear did not flush buffers");
    AST_LINE_FLUSH: assert property (lineStart |=> flushOutput)
        else $error("new command line did not flush output");
    AST_RESET_RELEASE: assert property ($rose(resetn) |->
        flushInput && !serviceRequest ##[1:4] !flushInput)
        else $error("power-on state wrong at reset release");
    cover property (serviceRequest ##1 !serviceRequest);
    cover property (serialPoll ##1 pollValid);
    cover property (deviceClear ##1 flushInput);
endmodule
bind status_reporting status_reporting_chk chk (.clk(clk), .resetn(resetn),
    .req(req), .deviceClear(deviceClear), .lineStart(lineStart),
    .serialPoll(serialPoll), .rdata(rdata), .rdataValid(rdataValid),
    .pollByte(pollByte), .pollValid(pollValid),
    .serviceRequest(serviceRequest), .flushOutput(flushOutput),
    .flushInput(flushInput));
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the status reporting block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import status_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    meas_cond_t meas = '0;
    logic [7:0] esrEvents = 8'h00;
    logic opcCommand = 1'b0, settingsPending = 1'b0, clearStatus = 1'b0;
    logic deviceClear = 1'b0, lineStart = 1'b0, errPush = 1'b0;
    logic outputPending = 1'b0;
    logic [15:0] errCode = 16'h0000;
    reg_req_t req;
    logic [15:0] rdata, got;
    logic [7:0] pollByte, pb;
    logic rdataValid, pollValid, serviceRequest, serialPoll;
    logic flushOutput, flushInput;
    int badCount = 0;
    int numChecks = 0;
    always #5 clk = ~clk;
    status_reporting dut (.clk(clk), .resetn(resetn), .req(req),
        .meas(meas), .esrEvents(esrEvents), .opcCommand(opcCommand),
        .settingsPending(settingsPending), .clearStatus(clearStatus),
        .deviceClear(deviceClear), .lineStart(lineStart),
        .serialPoll(serialPoll), .errPush(errPush), .errCode(errCode),
        .outputPending(outputPending), .rdata(rdata),
        .rdataValid(rdataValid), .pollByte(pollByte), .pollValid(pollValid),
        .serviceRequest(serviceRequest), .flushOutput(flushOutput),
        .flushInput(flushInput));
    remote_ctrl_model ctl (.clk(clk), .rdata(rdata), .rdataValid(rdataValid),
        .pollByte(pollByte), .pollValid(pollValid), .req(req),
        .serialPoll(serialPoll));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time,
                seen, exp);
        end
    endtask
    task automatic finishTest();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input reg_sel_t s, input reg_part_t p,
            input logic [15:0] d);
        ctl.xfer(1'b1, s, p, d, got);
    endtask
    task automatic rd(input reg_sel_t s, input reg_part_t p,
            input logic [15:0] e);
        ctl.xfer(1'b0, s, p, 16'h0000, got);
        check(got, e);
    endtask
    // bounded wait, then the level is judged once it has settled
    task automatic waitSrq(input logic e);
        int i;
        for (i = 0; i < 12 && serviceRequest !== e; i++) begin
            @(posedge clk);
            #1;
        end
        check({15'h0000, serviceRequest}, {15'h0000, e});
    endtask
    task automatic pushErr(input logic [15:0] code);
        @(posedge clk);
        errPush <= 1'b1;
        errCode <= code;
        @(posedge clk);
        errPush <= 1'b0;
        errCode <= ~code;
    endtask
    task automatic testResetValues();
        rd(SEL_SRE, PART_COND, 16'h0000);
        rd(SEL_QUES, PART_ENABLE, 16'h0000);
        rd(SEL_CURR, PART_PTR, 16'h3f3f);
        rd(SEL_OPER, PART_NTR, 16'h0000);
        rd(SEL_ERR, PART_COND, 16'h0000);
        rd(SEL_ESR, PART_EVENT, 16'h0080);
        wr(SEL_CURR, PART_COND, 16'hffff);
        rd(SEL_CURR, PART_COND, 16'h0000);
    endtask
    task automatic testRanges();
        wr(SEL_QUES, PART_ENABLE, 16'hffff);
        wr(SEL_CURR, PART_ENABLE, 16'hffff);
        wr(SEL_VOLT, PART_ENABLE, 16'hffff);
        @(posedge clk);
        meas.currAbove <= 6'h01;
        meas.currBelow <= 6'h20;
        meas.voltAbove <= 6'h20;
        meas.voltBelow <= 6'h01;
        meas.freqInvalid <= 1'b1;
        repeat (4) @(posedge clk);
        rd(SEL_CURR, PART_COND, 16'h2001);
        rd(SEL_VOLT, PART_COND, 16'h0120);
        rd(SEL_QUES, PART_COND, 16'h0023);
        rd(SEL_QUES, PART_ENABLE, 16'h0023);
        rd(SEL_CURR, PART_EVENT, 16'h2001);
        rd(SEL_CURR, PART_EVENT, 16'h0000);
        rd(SEL_VOLT, PART_EVENT, 16'h0120);
        rd(SEL_QUES, PART_EVENT, 16'h0023);
        @(posedge clk);
        meas <= '0;
    endtask
    task automatic testSrq();
        wr(SEL_QUES, PART_ENABLE, 16'h0020);
        wr(SEL_SRE, PART_COND, 16'h0008);
        outputPending <= 1'b1;
        waitSrq(1'b0);
        @(posedge clk);
        meas.freqInvalid <= 1'b1;
        waitSrq(1'b1);
        ctl.poll(pb);
        check({8'h00, pb}, 16'h0058);
        rd(SEL_STB, PART_COND, 16'h0058);
        rd(SEL_ERR, PART_COND, 16'h0000);
        rd(SEL_QUES, PART_EVENT, 16'h0020);
        waitSrq(1'b0);
        @(posedge clk);
        meas.freqInvalid <= 1'b0;
        outputPending <= 1'b0;
    endtask
    task automatic testOpc();
        wr(SEL_ESE, PART_COND, 16'h0001);
        wr(SEL_SRE, PART_COND, 16'h0020);
        settingsPending <= 1'b1;
        @(posedge clk);
        opcCommand <= 1'b1;
        esrEvents <= 8'h20;
        @(posedge clk);
        opcCommand <= 1'b0;
        esrEvents <= 8'h00;
        repeat (6) @(posedge clk);
        #1;
        check({15'h0000, serviceRequest}, 16'h0000);
        @(posedge clk);
        settingsPending <= 1'b0;
        waitSrq(1'b1);
        rd(SEL_ESR, PART_EVENT, 16'h0021);
        waitSrq(1'b0);
    endtask
    task automatic testOperNtr();
        wr(SEL_OPER, PART_ENABLE, 16'h0400);
        wr(SEL_OPER, PART_PTR, 16'h0000);
        wr(SEL_OPER, PART_NTR, 16'h0400);
        wr(SEL_SRE, PART_COND, 16'h0080);
        meas.operCond[10] <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check({15'h0000, serviceRequest}, 16'h0000);
        @(posedge clk);
        meas.operCond[10] <= 1'b0;
        waitSrq(1'b1);
        rd(SEL_OPER, PART_EVENT, 16'h0400);
        waitSrq(1'b0);
    endtask
    task automatic testErrors();
        pushErr(16'h0071);
        pushErr(16'h0072);
        pushErr(16'h0073);
        ctl.poll(pb);
        check({8'h00, pb}, 16'h0004);
        rd(SEL_ERR, PART_COND, 16'h0071);
        rd(SEL_ERR, PART_COND, 16'h0072);
        rd(SEL_ERR, PART_COND, 16'h0073);
        rd(SEL_ERR, PART_COND, 16'h0000);
    endtask
    task automatic testClear();
        pushErr(16'h0055);
        @(posedge clk);
        deviceClear <= 1'b1;
        lineStart <= 1'b1;
        @(posedge clk);
        deviceClear <= 1'b0;
        lineStart <= 1'b0;
        #1;
        check({14'h0000, flushOutput, flushInput}, 16'h0003);
        rd(SEL_ERR, PART_COND, 16'h0055);
        rd(SEL_OPER, PART_NTR, 16'h0400);
        pushErr(16'h0056);
        @(posedge clk);
        clearStatus <= 1'b1;
        @(posedge clk);
        clearStatus <= 1'b0;
        rd(SEL_ERR, PART_COND, 16'h0000);
        rd(SEL_OPER, PART_PTR, 16'h7fff);
        rd(SEL_CURR, PART_NTR, 16'h3f3f);
        rd(SEL_SRE, PART_COND, 16'h0080);
        wr(SEL_SRE, PART_COND, 16'h00ff);
        rd(SEL_SRE, PART_COND, 16'h00bf);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        testResetValues();
        testRanges();
        testSrq();
        testOpc();
        testOperNtr();
        testErrors();
        testClear();
        finishTest();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        badCount++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        finishTest();
    end
endmodule
`default_nettype wire
